//--- oml_top.sv
// Optical module control/status with two-page 2-wire management port
//
// Contract
// - Transmitter is off while the transmit-off input is high.
// - Transmit-off defaults to disabled until the host drives it low.
// - Bit 6 of byte 110 disables; bit 7 shows transmit-off state.
// - Software bit 6 and hardware transmit-off are ORed.
// - A catastrophic laser fault raises the fault output and stops the laser.
// - Fault latches; cleared only by toggling transmit-off or power cycle.
// - Fault output low when healthy, high on fault; open collector.
// - Transmitter fault readable as bit 2 of byte 110.
// - Loss-of-signal output high when optical input is unusable.
// - Loss-of-signal readable as bit 1 of byte 110.
// - Two 256-byte pages: identification at a0, diagnostics at a2.
// - Management port follows 2-wire serial EEPROM protocol, host is master.
// - Eye-safety monitor disables the transmitter on an unsafe condition.
`timescale 1ns/1ps
module oml_top #(
  parameter logic [255:0][7:0] ID_CONTENT = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic tx_disable_pin,
  input wire logic laser_fault_detect,
  input wire logic eye_unsafe,
  input wire logic rx_signal_weak,
  output logic laser_enable,
  output logic tx_fault_o,
  output logic tx_fault_oe,
  output logic receive_signal_lost
);
  typedef struct packed {
    oml_pkg::oml_mgmt_st_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic page;
    logic scl_q;
    logic sda_q;
    logic sda_oe;
    logic soft_dis;
    logic [oml_pkg::PAGE_BYTES-1:0][7:0] diag;
  } oml_mgmt_state_t;

  logic [1:0] rst_sync;
  logic rst_n;
  oml_mgmt_state_t r;
  oml_mgmt_state_t next_r;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] rd_val;
  logic [7:0] cs_live;
  logic [7:0] ptr_inc;

  oml_ctrl_if ctl ();

  // Reset released through two flops; asserted at once
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  oml_tx_ctrl u_tx_ctrl (
    .clk(clk),
    .rst_n(rst_n),
    .tx_disable_pin(tx_disable_pin),
    .laser_fault_detect(laser_fault_detect),
    .eye_unsafe(eye_unsafe),
    .rx_signal_weak(rx_signal_weak),
    .ctl(ctl),
    .laser_enable(laser_enable),
    .tx_fault_oe(tx_fault_oe),
    .receive_signal_lost(receive_signal_lost)
  );

  assign ctl.soft_disable = r.soft_dis;

  // Byte 110 is assembled from live state, never from stored copies
  always_comb begin
    cs_live = 8'h00;
    cs_live[oml_pkg::CS_PIN_DISABLE_BIT] = ctl.pin_disable;
    cs_live[oml_pkg::CS_SOFT_DISABLE_BIT] = r.soft_dis;
    cs_live[oml_pkg::CS_TX_FAULT_BIT] = ctl.tx_fault;
    cs_live[oml_pkg::CS_RX_LOST_BIT] = ctl.rx_lost;
  end

  always_comb begin
    if (r.page == oml_pkg::PAGE_ID) begin
      rd_val = ID_CONTENT[r.ptr];
    end else if (r.ptr == oml_pkg::CS_OFFSET) begin
      rd_val = cs_live;
    end else begin
      rd_val = r.diag[r.ptr];
    end
  end

  assign ptr_inc = r.ptr + 8'h01;
  assign scl_rise = scl & ~r.scl_q;
  assign scl_fall = ~scl & r.scl_q;
  assign start_cond = scl & r.scl_q & r.sda_q & ~sda_i;
  assign stop_cond = scl & r.scl_q & ~r.sda_q & sda_i;

  always_comb begin
    next_r = r;
    next_r.scl_q = scl;
    next_r.sda_q = sda_i;
    if (start_cond) begin
      next_r.st = oml_pkg::MG_DEV;
      next_r.bitcnt = 4'h0;
      next_r.sda_oe = 1'b0;
    end else if (stop_cond) begin
      next_r.st = oml_pkg::MG_IDLE;
      next_r.sda_oe = 1'b0;
    end else begin
      unique case (r.st)
        oml_pkg::MG_IDLE: begin
          next_r.sda_oe = 1'b0;
        end
        oml_pkg::MG_DEV, oml_pkg::MG_WORD, oml_pkg::MG_WRITE: begin
          if (scl_rise && r.bitcnt != 4'(oml_pkg::BYTE_BITS)) begin
            next_r.shreg = {r.shreg[6:0], sda_i};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == 4'(oml_pkg::BYTE_BITS)) begin
            next_r.bitcnt = 4'h0;
            next_r.sda_oe = 1'b1;
            if (r.st == oml_pkg::MG_DEV) begin
              // Only the two page addresses are answered; others get no ack
              if (r.shreg[7:1] == oml_pkg::DEV_ID
                  || r.shreg[7:1] == oml_pkg::DEV_DIAG) begin
                next_r.page = r.shreg[1];
                next_r.st = r.shreg[0] ? oml_pkg::MG_ACK_RD
                                       : oml_pkg::MG_ACK_DEV;
              end else begin
                next_r.sda_oe = 1'b0;
                next_r.st = oml_pkg::MG_IDLE;
              end
            end else if (r.st == oml_pkg::MG_WORD) begin
              next_r.ptr = r.shreg;
              next_r.st = oml_pkg::MG_ACK_WORD;
            end else begin
              // Identification page is read-only; writes are acked, dropped
              if (r.page == oml_pkg::PAGE_DIAG) begin
                if (r.ptr == oml_pkg::CS_OFFSET) begin
                  next_r.soft_dis =
                    r.shreg[oml_pkg::CS_SOFT_DISABLE_BIT];
                end else begin
                  next_r.diag[r.ptr] = r.shreg;
                end
              end
              next_r.ptr = ptr_inc;
              next_r.st = oml_pkg::MG_ACK_WR;
            end
          end
        end
        oml_pkg::MG_ACK_DEV, oml_pkg::MG_ACK_WORD, oml_pkg::MG_ACK_WR: begin
          if (scl_fall) begin
            next_r.sda_oe = 1'b0;
            next_r.bitcnt = 4'h0;
            next_r.st = (r.st == oml_pkg::MG_ACK_DEV) ? oml_pkg::MG_WORD
                                                      : oml_pkg::MG_WRITE;
          end
        end
        oml_pkg::MG_ACK_RD: begin
          // Load the byte and put its top bit out while the clock is low
          if (scl_fall) begin
            next_r.shreg = rd_val;
            next_r.ptr = ptr_inc;
            next_r.sda_oe = ~rd_val[7];
            next_r.bitcnt = 4'h1;
            next_r.st = oml_pkg::MG_READ;
          end
        end
        oml_pkg::MG_READ: begin
          if (scl_fall) begin
            if (r.bitcnt == 4'(oml_pkg::BYTE_BITS)) begin
              next_r.sda_oe = 1'b0;
              next_r.st = oml_pkg::MG_MACK;
            end else begin
              next_r.shreg = {r.shreg[6:0], 1'b0};
              next_r.sda_oe = ~r.shreg[6];
              next_r.bitcnt = r.bitcnt + 4'h1;
            end
          end
        end
        oml_pkg::MG_MACK: begin
          // Master ack continues sequential read, nack ends it
          if (scl_rise) begin
            next_r.st = sda_i ? oml_pkg::MG_IDLE : oml_pkg::MG_ACK_RD;
          end
        end
        default: begin
          next_r.st = oml_pkg::MG_IDLE;
          next_r.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r.st <= oml_pkg::MG_IDLE;
      r.bitcnt <= 4'h0;
      r.shreg <= 8'h00;
      r.ptr <= 8'h00;
      r.page <= oml_pkg::PAGE_ID;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
      r.sda_oe <= 1'b0;
      r.soft_dis <= oml_pkg::CS_SOFT_DISABLE_RST;
      r.diag <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_o <= 1'b0;
      tx_fault_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      tx_fault_o <= 1'b0;
    end
  end

  assign sda_oe = r.sda_oe;
endmodule : oml_top

//--- oml_pkg.sv
// Constants and types shared by the optical module control and status logic
package oml_pkg;
  // 7-bit management device addresses of the two pages (8-bit forms a0, a2)
  localparam logic [6:0] DEV_ID = 7'h50;
  localparam logic [6:0] DEV_DIAG = 7'h51;
  localparam logic PAGE_ID = 1'b0;
  localparam logic PAGE_DIAG = 1'b1;
  localparam int PAGE_BYTES = 256;
  // Control/status byte in the diagnostic page and its fields
  localparam logic [7:0] CS_OFFSET = 8'h6e;
  localparam int CS_PIN_DISABLE_BIT = 7;
  localparam int CS_SOFT_DISABLE_BIT = 6;
  localparam int CS_TX_FAULT_BIT = 2;
  localparam int CS_RX_LOST_BIT = 1;
  localparam logic CS_SOFT_DISABLE_RST = 1'b0;
  // Transmit-off input reads as asserted until first sampled after reset
  localparam logic PIN_DISABLE_RST = 1'b1;
  localparam logic TX_FAULT_RST = 1'b0;
  localparam logic RX_LOST_RST = 1'b0;
  localparam int BYTE_BITS = 8;

  typedef enum logic [3:0] {
    MG_IDLE = 4'h0,
    MG_DEV = 4'h1,
    MG_ACK_DEV = 4'h2,
    MG_WORD = 4'h3,
    MG_ACK_WORD = 4'h4,
    MG_WRITE = 4'h5,
    MG_ACK_WR = 4'h6,
    MG_ACK_RD = 4'h7,
    MG_READ = 4'h8,
    MG_MACK = 4'h9
  } oml_mgmt_st_t;
endpackage : oml_pkg

//--- oml_ctrl_if.sv
// Signals between the management engine and the transmitter control
`timescale 1ns/1ps
interface oml_ctrl_if;
  logic soft_disable;
  logic pin_disable;
  logic tx_fault;
  logic rx_lost;
  modport mgmt (output soft_disable, input pin_disable, tx_fault, rx_lost);
  modport txc (input soft_disable, output pin_disable, tx_fault, rx_lost);
endinterface : oml_ctrl_if

//--- oml_tx_ctrl.sv
// Transmitter enable, latched laser fault and loss-of-signal status
`timescale 1ns/1ps
module oml_tx_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_disable_pin,
  input wire logic laser_fault_detect,
  input wire logic eye_unsafe,
  input wire logic rx_signal_weak,
  oml_ctrl_if.txc ctl,
  output logic laser_enable,
  output logic tx_fault_oe,
  output logic receive_signal_lost
);
  typedef struct packed {
    logic pin_dis;
    logic fault;
    logic los;
    logic laser_en;
    logic fault_oe;
  } oml_txc_state_t;

  oml_txc_state_t r;
  oml_txc_state_t next_r;
  logic fault_now;
  logic pin_rise;

  always_comb begin
    next_r = r;
    // Eye-safety trip counts as a fault so it needs the same reset cycle
    fault_now = laser_fault_detect | eye_unsafe;
    pin_rise = tx_disable_pin & ~r.pin_dis;
    next_r.pin_dis = tx_disable_pin;
    // Set wins over a clearing toggle in the same cycle
    next_r.fault = fault_now | (r.fault & ~pin_rise);
    next_r.los = rx_signal_weak;
    next_r.laser_en = ~(tx_disable_pin | ctl.soft_disable | fault_now
                        | next_r.fault);
    // Open collector: pull low while healthy, release on fault
    next_r.fault_oe = ~next_r.fault;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r.pin_dis <= oml_pkg::PIN_DISABLE_RST;
      r.fault <= oml_pkg::TX_FAULT_RST;
      r.los <= oml_pkg::RX_LOST_RST;
      r.laser_en <= 1'b0;
      r.fault_oe <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign ctl.pin_disable = r.pin_dis;
  assign ctl.tx_fault = r.fault;
  assign ctl.rx_lost = r.los;
  assign laser_enable = r.laser_en;
  assign tx_fault_oe = r.fault_oe;
  assign receive_signal_lost = r.los;
endmodule : oml_tx_ctrl

//--- oml_properties.sv
// Port assertions for the optical module control/status block
`timescale 1ns/1ps
module oml_properties (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda_oe,
  input wire logic tx_disable_pin,
  input wire logic laser_fault_detect,
  input wire logic eye_unsafe,
  input wire logic rx_signal_weak,
  input wire logic laser_enable,
  input wire logic tx_fault_oe,
  input wire logic receive_signal_lost
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Inputs count only once the two-flop reset copy has let go
  sequence s_up;
    $past(arst_n, 1) && $past(arst_n, 2) && $past(arst_n, 3);
  endsequence
  sequence s_hit;
    $past(arst_n, 1) && $past(arst_n, 2) && $past(arst_n, 3)
    && (laser_fault_detect || eye_unsafe);
  endsequence
  sequence s_toggle;
    !tx_fault_oe && !tx_disable_pin ##1
    tx_disable_pin && !laser_fault_detect && !eye_unsafe;
  endsequence
  AST_PIN_OFF: assert property (tx_disable_pin |=> !laser_enable)
    else $error("laser on with pin high");
  AST_TRIP: assert property (s_hit |=> !laser_enable && !tx_fault_oe)
    else $error("fault not raised");
  AST_HOLD: assert property (
    !tx_fault_oe && !tx_disable_pin |=> !tx_fault_oe)
    else $error("fault cleared without toggle");
  AST_CLEAR: assert property (s_toggle |=> tx_fault_oe)
    else $error("toggle did not clear fault");
  AST_CAUSE: assert property (
    $fell(tx_fault_oe) |-> $past(laser_fault_detect) || $past(eye_unsafe))
    else $error("fault output without a cause");
  AST_LOST: assert property (
    s_up |=> receive_signal_lost == $past(rx_signal_weak))
    else $error("lost flag not one clock behind");
  AST_ON: assert property (
    $rose(laser_enable) |-> !$past(tx_disable_pin) && tx_fault_oe)
    else $error("laser on while disabled");
  AST_SDA: assert property ($changed(sda_oe) |-> !scl && !$past(scl))
    else $error("sda moved while scl high");
endmodule : oml_properties

bind oml_top oml_properties i_props (
  .clk, .arst_n, .scl, .sda_oe, .tx_disable_pin, .laser_fault_detect,
  .eye_unsafe, .rx_signal_weak, .laser_enable, .tx_fault_oe,
  .receive_signal_lost);

//--- oml_host_model.sv
// Behavioural 2-wire management master for the optical module
`timescale 1ns/1ps
module oml_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves mid-low; a differs from z only for start or stop
  task automatic slot(input logic a, input logic z, output logic got);
    scl <= 1'b0;
    repeat (4) @(posedge clk);
    sda_low <= a;
    repeat (4) @(posedge clk);
    scl <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk) got = sda;
    repeat (4) @(posedge clk);
    sda_low <= z;
    // Hold the level so sda never moves in the same step as scl
    repeat (4) @(posedge clk);
  endtask : slot
  task automatic put(input logic [7:0] v, inout logic ok);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      slot(!v[i], !v[i], g);
    end
    slot(1'b0, 1'b0, g);
    ok = ok && !g;
  endtask : put
  task automatic xfer(input logic [7:0] dev, input logic [7:0] a,
                      input logic [7:0] d, input logic rd,
                      output logic [7:0] q, output logic ok);
    logic g;
    ok = 1'b1;
    @(posedge clk);
    slot(1'b0, 1'b1, g);
    put(dev, ok);
    put(a, ok);
    if (rd) begin
      slot(1'b0, 1'b1, g);
      put(dev | 8'h01, ok);
      for (int i = 7; i >= 0; i--) begin
        slot(1'b0, 1'b0, q[i]);
      end
      slot(1'b0, 1'b0, g);
    end else begin
      put(d, ok);
    end
    slot(1'b1, 1'b0, g);
    // Idle gap so stop and the next start never share a sample
    repeat (4) @(posedge clk);
  endtask : xfer
  // Current-address read of two bytes; master acks the first
  task automatic cur2(input logic [7:0] dev, output logic [15:0] q,
                      output logic ok);
    logic g;
    ok = 1'b1;
    @(posedge clk);
    slot(1'b0, 1'b1, g);
    put(dev | 8'h01, ok);
    for (int i = 15; i >= 0; i--) begin
      slot(1'b0, 1'b0, q[i]);
      if (i == 8) begin
        slot(1'b1, 1'b1, g);
      end
    end
    slot(1'b0, 1'b0, g);
    slot(1'b1, 1'b0, g);
    repeat (4) @(posedge clk);
  endtask : cur2
endmodule : oml_host_model

//--- oml_top_tb_top.sv
// Self-checking bench for the optical module control/status block
`timescale 1ns/1ps
module oml_top_tb_top;
  typedef struct packed {
    logic [3:0] pins;
    logic [2:0] outs;
    logic [7:0] cs;
  } oml_row_t;
  localparam logic [7:0] DIAG = {oml_pkg::DEV_DIAG, 1'b0};
  localparam logic [7:0] IDP = {oml_pkg::DEV_ID, 1'b0};
  localparam logic [7:0] CSA = oml_pkg::CS_OFFSET;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] pins = 4'h8;
  logic tx_disable_pin, laser_fault_detect, eye_unsafe, rx_signal_weak;
  logic scl, sda_low, sda, sda_o, sda_oe, laser_enable, ok;
  logic tx_fault_o, tx_fault_oe, receive_signal_lost;
  logic [2:0] outs;
  logic [7:0] rd_v;
  logic [15:0] rd_w;
  int miscompares = 0;
  int samples_checked = 0;
  // Pins {off, fault, eye, weak}; outs {laser, fault_oe, lost}; byte
  // Off pulses are far tighter than a real host spaces them
  oml_row_t rows [10] = '{
    '{4'h0, 3'h6, 8'h00}, '{4'h8, 3'h2, 8'h80}, '{4'h1, 3'h7, 8'h02},
    '{4'h4, 3'h0, 8'h04}, '{4'hc, 3'h0, 8'h84}, '{4'h0, 3'h0, 8'h04},
    '{4'h8, 3'h2, 8'h80}, '{4'h2, 3'h0, 8'h04}, '{4'h8, 3'h2, 8'h80},
    '{4'h0, 3'h6, 8'h00}};
  always #2 clk = ~clk;
  assign {tx_disable_pin, laser_fault_detect, eye_unsafe, rx_signal_weak} =
    pins;
  assign outs = {laser_enable, tx_fault_oe, receive_signal_lost};
  // Released sda floats high on the host pull-up
  assign sda = !(sda_oe && !sda_o) && !sda_low;
  oml_top #(.ID_CONTENT({256{8'h3c}})) i_dut (
    .clk, .arst_n, .scl, .sda_i(sda), .sda_o, .sda_oe, .tx_disable_pin,
    .laser_fault_detect, .eye_unsafe, .rx_signal_weak, .laser_enable,
    .tx_fault_o, .tx_fault_oe, .receive_signal_lost);
  oml_host_model i_host (.clk, .sda, .scl, .sda_low);
  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  task automatic rd_cs(input logic [7:0] dev, input logic [7:0] a,
                       input logic [7:0] exp);
    i_host.xfer(dev, a, 8'h00, 1'b1, rd_v, ok);
    chk("ack", 8'h01, 8'(ok));
    chk("data", exp, rd_v);
  endtask : rd_cs
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(negedge clk);
    chk("laser", 8'h00, 8'(laser_enable));
    rd_cs(DIAG, CSA, 8'h80);
    $display("reset test done");
    foreach (rows[i]) begin
      @(posedge clk);
      pins <= rows[i].pins;
      repeat (3) @(negedge clk);
      chk("outs", 8'(rows[i].outs), 8'(outs));
      rd_cs(DIAG, CSA, rows[i].cs);
      $display("row test %0d done", i);
    end
    i_host.xfer(DIAG, CSA, 8'hff, 1'b0, rd_v, ok);
    chk("laser", 8'h00, 8'(laser_enable));
    rd_cs(DIAG, CSA, 8'h40);
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    chk("rst", 8'h04, 8'({laser_enable, tx_fault_oe, tx_fault_o, sda_oe}));
    @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(negedge clk);
    chk("laser", 8'h01, 8'(laser_enable));
    rd_cs(DIAG, CSA, 8'h00);
    $display("soft disable test done");
    i_host.xfer(DIAG, 8'h10, 8'h5a, 1'b0, rd_v, ok);
    rd_cs(DIAG, 8'h10, 8'h5a);
    i_host.xfer(DIAG, 8'h11, 8'hc3, 1'b0, rd_v, ok);
    chk("ack", 8'h01, 8'(ok));
    rd_cs(DIAG, 8'h0f, 8'h00);
    // Current read from 0x10 with a master ack between the two bytes
    i_host.cur2(DIAG, rd_w, ok);
    chk("ack", 8'h01, 8'(ok));
    chk("seq0", 8'h5a, rd_w[15:8]);
    chk("seq1", 8'hc3, rd_w[7:0]);
    i_host.xfer(IDP, 8'h10, 8'ha5, 1'b0, rd_v, ok);
    chk("ack", 8'h01, 8'(ok));
    rd_cs(IDP, 8'h10, 8'h3c);
    i_host.xfer(8'ha4, 8'h10, 8'h00, 1'b0, rd_v, ok);
    chk("nak", 8'h00, 8'(ok));
    $display("page test done");
    close_out();
  end
endmodule : oml_top_tb_top
